// File: hdl/cskda_params.svh
/*
 * constants for the compare-skip and decimal-adjust execution block:
 * opcode patterns, register offsets, field positions, reset values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef CSKDA_PARAMS_SVH
`define CSKDA_PARAMS_SVH

// opcode patterns, upper seven bits of the word; decimal adjust matches the whole word
`define CSKDA_OPC_HI_W 7
`define CSKDA_OPC_CEQ 7'h31
`define CSKDA_OPC_CGT 7'h32
`define CSKDA_OPC_CLT 7'h30
`define CSKDA_OPC_DAW 16'h0007

// instruction fields
`define CSKDA_BANK_BIT 8
`define CSKDA_ADDR_MSB 7

// decimal adjust limits
`define CSKDA_BCD_MAX 4'h9
`define CSKDA_BCD_FIX 4'h6

// access bank layout
`define CSKDA_ACC_SPLIT 7
`define CSKDA_ACC_LOW_BANK 4'h0
`define CSKDA_ACC_HIGH_BANK 4'hf

// register byte offsets
`define CSKDA_OFF_WORK 8'h00
`define CSKDA_OFF_BANK 8'h04
`define CSKDA_OFF_FLAGS 8'h08
`define CSKDA_OFF_EXEC 8'h0c

// flag register fields
`define CSKDA_FLAG_C 0
`define CSKDA_FLAG_DC 1

// exec register fields
`define CSKDA_EXEC_PEND 0
`define CSKDA_EXEC_PEND2 1
`define CSKDA_EXEC_LAST 2
`define CSKDA_EXEC_NOP 3
`define CSKDA_EXEC_PH_LSB 4

// reset values
`define CSKDA_RST_WORK 8'h00
`define CSKDA_RST_BANK 4'h0
`define CSKDA_RST_FLAGS 2'h0

`endif

// File: hdl/cskda_pkg.sv
/*
 * types for the compare-skip and decimal-adjust execution block.
 * assumes nothing beyond a systemverilog compiler.
 */
package cskda_pkg;

    typedef enum logic [3:0] {
        CSKDA_Q1 = 4'b0001,
        CSKDA_Q2 = 4'b0010,
        CSKDA_Q3 = 4'b0100,
        CSKDA_Q4 = 4'b1000
    } cskda_phase_t;

    typedef enum logic [4:0] {
        CSKDA_OP_NONE = 5'b00001,
        CSKDA_OP_CEQ = 5'b00010,
        CSKDA_OP_CGT = 5'b00100,
        CSKDA_OP_CLT = 5'b01000,
        CSKDA_OP_DAW = 5'b10000
    } cskda_op_t;

endpackage : cskda_pkg

// File: hdl/cskda_alu_if.sv
/*
 * carrier between the sequencer and its compare / decimal-adjust unit.
 * assumes both ends on the same clock; the unit is combinational.
 */
`timescale 1ns/1ps
interface cskda_alu_if;
    import cskda_pkg::*;
    cskda_op_t op;
    logic [7:0] file_byte;
    logic [7:0] work;
    logic carry;
    logic digit_carry;
    logic skip;
    logic [7:0] adj_work;
    logic adj_carry;

    modport core (output op, output file_byte, output work, output carry, output digit_carry,
                  input skip, input adj_work, input adj_carry);
    modport unit (input op, input file_byte, input work, input carry, input digit_carry,
                  output skip, output adj_work, output adj_carry);
endinterface : cskda_alu_if

// File: hdl/cskda_alu.sv
/*
 * compare and decimal-adjust datapath.
 * assumes operands are stable registers of the sequencer.
 */
`timescale 1ns/1ps
`include "cskda_params.svh"
module cskda_alu
    import cskda_pkg::*;
(
    // datapath carrier
    cskda_alu_if.unit alu
);
    logic [8:0] diff;
    logic is_equal;
    logic is_less;
    logic is_greater;
    logic [3:0] lo_fixed;
    logic [4:0] hi_sum;

    // unsigned subtraction, result only looked at
    assign diff = {1'b0, alu.file_byte} - {1'b0, alu.work};
    assign is_equal = (diff == 9'h000);
    assign is_less = diff[8];
    assign is_greater = !diff[8] && !is_equal;

    always_comb begin
        case (alu.op)
            CSKDA_OP_CEQ: alu.skip = is_equal;
            CSKDA_OP_CGT: alu.skip = is_greater;
            CSKDA_OP_CLT: alu.skip = is_less;
            default: alu.skip = 1'b0;
        endcase
    end

    // low nibble correction
    always_comb begin
        if ((alu.work[3:0] > `CSKDA_BCD_MAX) || alu.digit_carry) begin
            lo_fixed = alu.work[3:0] + `CSKDA_BCD_FIX;
        end else begin
            lo_fixed = alu.work[3:0];
        end
    end

    // high nibble correction with carry out
    always_comb begin
        if ((alu.work[7:4] > `CSKDA_BCD_MAX) || alu.carry) begin
            hi_sum = {1'b0, alu.work[7:4]} + {1'b0, `CSKDA_BCD_FIX};
        end else begin
            hi_sum = {1'b0, alu.work[7:4]};
        end
    end

    assign alu.adj_work = {hi_sum[3:0], lo_fixed};
    assign alu.adj_carry = alu.carry | hi_sum[4];
endmodule : cskda_alu

// File: hdl/cskda_core.sv
/*
 * four-phase execution of the three compare-and-skip instructions and the
 * decimal adjust of the working register, with a wishbone register slave.
 * assumes the fetch pipeline presents the next word at phase one, flags
 * two-word instructions, and the data memory answers a read by phase three.
 */
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "cskda_params.svh"
module cskda_core
    import cskda_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // instruction from fetch
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_two_word_i,
    // data memory
    output logic [11:0] mem_addr_o,
    output logic mem_rd_o,
    input wire logic [7:0] mem_rdata_i,
    // execution status
    output logic [3:0] phase_o,
    output logic nop_cycle_o,
    output logic skip_taken_o,
    output logic cycle_end_o
);
    cskda_alu_if alu_bus ();

    cskda_alu u_alu (
        .alu (alu_bus.unit)
    );

    cskda_phase_t phase_reg;
    cskda_op_t op_reg;
    cskda_op_t op_next;
    logic [7:0] work_reg;
    logic [3:0] bank_reg;
    logic carry_reg;
    logic digit_carry_reg;
    logic [7:0] file_reg;
    logic [7:0] faddr_reg;
    logic bank_sel_reg;
    logic skip_pend_reg;
    logic skip_pend2_reg;
    logic nop_reg;
    logic last_skip_reg;
    logic [11:0] mem_addr_reg;
    logic mem_rd_reg;
    logic skip_taken_reg;
    logic cycle_end_reg;
    logic [31:0] rdata_reg;
    logic ack_reg;
    logic bus_req;
    logic bus_wr;
    logic daw_write;
    logic [11:0] addr_next;

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign daw_write = (phase_reg == CSKDA_Q4) && (op_reg == CSKDA_OP_DAW) && !nop_reg;

    // four phases per instruction cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= CSKDA_Q1;
        end else begin
            case (phase_reg)
                CSKDA_Q1: phase_reg <= CSKDA_Q2;
                CSKDA_Q2: phase_reg <= CSKDA_Q3;
                CSKDA_Q3: phase_reg <= CSKDA_Q4;
                CSKDA_Q4: phase_reg <= CSKDA_Q1;
                default: phase_reg <= CSKDA_Q1;
            endcase
        end
    end

    // opcode decode
    always_comb begin
        op_next = CSKDA_OP_NONE;
        if (instr_i == `CSKDA_OPC_DAW) begin
            op_next = CSKDA_OP_DAW;
        end else begin
            case (instr_i[15:9])
                `CSKDA_OPC_CEQ: op_next = CSKDA_OP_CEQ;
                `CSKDA_OPC_CGT: op_next = CSKDA_OP_CGT;
                `CSKDA_OPC_CLT: op_next = CSKDA_OP_CLT;
                default: op_next = CSKDA_OP_NONE;
            endcase
        end
    end

    // phase one: take the word, or squash it when a skip is pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_reg <= CSKDA_OP_NONE;
            nop_reg <= 1'b0;
            faddr_reg <= 8'h00;
            bank_sel_reg <= 1'b0;
        end else if (phase_reg == CSKDA_Q1) begin
            if (skip_pend_reg || skip_pend2_reg) begin
                op_reg <= CSKDA_OP_NONE;
                nop_reg <= 1'b1;
            end else if (instr_valid_i) begin
                op_reg <= op_next;
                nop_reg <= 1'b0;
                faddr_reg <= instr_i[`CSKDA_ADDR_MSB:0];
                bank_sel_reg <= instr_i[`CSKDA_BANK_BIT];
            end else begin
                op_reg <= CSKDA_OP_NONE;
                nop_reg <= 1'b0;
            end
        end
    end

    // skip bookkeeping: one squashed word, two for a two-word victim
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skip_pend_reg <= 1'b0;
            skip_pend2_reg <= 1'b0;
        end else if (phase_reg == CSKDA_Q1) begin
            if (skip_pend_reg) begin
                skip_pend_reg <= 1'b0;
                skip_pend2_reg <= instr_valid_i && instr_two_word_i;
            end else begin
                skip_pend2_reg <= 1'b0;
            end
        end else if ((phase_reg == CSKDA_Q4) && !nop_reg && alu_bus.skip) begin
            skip_pend_reg <= 1'b1;
        end
    end

    // data address: access bank or bank select register
    always_comb begin
        if (bank_sel_reg) begin
            addr_next = {bank_reg, faddr_reg};
        end else if (faddr_reg[`CSKDA_ACC_SPLIT]) begin
            addr_next = {`CSKDA_ACC_HIGH_BANK, faddr_reg};
        end else begin
            addr_next = {`CSKDA_ACC_LOW_BANK, faddr_reg};
        end
    end

    // phase two read request, phase three capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_addr_reg <= 12'h000;
            mem_rd_reg <= 1'b0;
            file_reg <= 8'h00;
        end else begin
            if ((phase_reg == CSKDA_Q1) && !skip_pend_reg && !skip_pend2_reg && instr_valid_i &&
                (op_next != CSKDA_OP_NONE) && (op_next != CSKDA_OP_DAW)) begin
                mem_rd_reg <= 1'b1;
            end else if (phase_reg == CSKDA_Q3) begin
                mem_rd_reg <= 1'b0;
            end
            if (phase_reg == CSKDA_Q2) begin
                mem_addr_reg <= addr_next;
            end
            if ((phase_reg == CSKDA_Q3) && mem_rd_reg) begin
                file_reg <= mem_rdata_i;
            end
        end
    end

    // working register: decimal adjust result wins over a bus write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            work_reg <= `CSKDA_RST_WORK;
        end else if (daw_write) begin
            work_reg <= alu_bus.adj_work;
        end else if (bus_wr && (wb_adr_i == `CSKDA_OFF_WORK)) begin
            work_reg <= wb_dat_i[7:0];
        end
    end

    // carry: decimal adjust and bus writes touch it, compares never do
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry_reg <= 1'(`CSKDA_RST_FLAGS >> `CSKDA_FLAG_C);
            digit_carry_reg <= 1'(`CSKDA_RST_FLAGS >> `CSKDA_FLAG_DC);
        end else begin
            if (daw_write) begin
                carry_reg <= alu_bus.adj_carry;
            end else if (bus_wr && (wb_adr_i == `CSKDA_OFF_FLAGS)) begin
                carry_reg <= wb_dat_i[`CSKDA_FLAG_C];
            end
            if (bus_wr && (wb_adr_i == `CSKDA_OFF_FLAGS)) begin
                digit_carry_reg <= wb_dat_i[`CSKDA_FLAG_DC];
            end
        end
    end

    // bank select register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_reg <= `CSKDA_RST_BANK;
        end else if (bus_wr && (wb_adr_i == `CSKDA_OFF_BANK)) begin
            bank_reg <= wb_dat_i[3:0];
        end
    end

    // end-of-cycle reporting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skip_taken_reg <= 1'b0;
            cycle_end_reg <= 1'b0;
            last_skip_reg <= 1'b0;
        end else begin
            cycle_end_reg <= (phase_reg == CSKDA_Q4);
            if (phase_reg == CSKDA_Q4) begin
                skip_taken_reg <= !nop_reg && alu_bus.skip;
                if (!nop_reg && (op_reg != CSKDA_OP_NONE) && (op_reg != CSKDA_OP_DAW)) begin
                    last_skip_reg <= alu_bus.skip;
                end
            end else begin
                skip_taken_reg <= 1'b0;
            end
        end
    end

    // datapath operands
    assign alu_bus.op = op_reg;
    assign alu_bus.file_byte = file_reg;
    assign alu_bus.work = work_reg;
    assign alu_bus.carry = carry_reg;
    assign alu_bus.digit_carry = digit_carry_reg;

    // wishbone: answer one cycle after the request, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `CSKDA_OFF_WORK: rdata_reg <= {24'h00_0000, work_reg};
                    `CSKDA_OFF_BANK: rdata_reg <= {28'h000_0000, bank_reg};
                    `CSKDA_OFF_FLAGS: rdata_reg <= {30'h0000_0000, digit_carry_reg, carry_reg};
                    `CSKDA_OFF_EXEC: rdata_reg <= {24'h00_0000, phase_reg, nop_reg, last_skip_reg,
                                                   skip_pend2_reg, skip_pend_reg};
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign mem_addr_o = mem_addr_reg;
    assign mem_rd_o = mem_rd_reg;
    assign phase_o = phase_reg;
    assign nop_cycle_o = nop_reg;
    assign skip_taken_o = skip_taken_reg;
    assign cycle_end_o = cycle_end_reg;
endmodule : cskda_core

// File: tb/cskda_core_asserts.sv
/* port assertions for the compare-skip core.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
module cskda_core_asserts (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // fetch
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_two_word_i,
    // memory
    input wire logic [11:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic [7:0] mem_rdata_i,
    // status
    input wire logic [3:0] phase_o,
    input wire logic nop_cycle_o,
    input wire logic skip_taken_o,
    input wire logic cycle_end_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    phase_step_a: assert property (phase_o != 4'h8 |=> phase_o == $past(phase_o) << 1)
        else $error("phase did not advance");
    cycle_wrap_a: assert property (phase_o == 4'h8 |=> phase_o == 4'h1 && cycle_end_o)
        else $error("cycle end missing");
    skip_squash_a: assert property (skip_taken_o |-> phase_o == 4'h1 ##1 nop_cycle_o [*3])
        else $error("skip without squashed cycle");
    skip_cause_a: assert property (skip_taken_o |-> $past(instr_valid_i, 4) &&
        $past(instr_i[15:11], 4) == 5'b01100 && $past(instr_i[10:9], 4) != 2'b11)
        else $error("skip not caused by a compare");
    read_cause_a: assert property ($rose(mem_rd_o) |-> $past(instr_valid_i) &&
        $past(instr_i[15:11]) == 5'b01100 && $past(phase_o) == 4'h1)
        else $error("memory read without compare");
    access_bank_a: assert property (phase_o == 4'h4 && mem_rd_o && !$past(instr_i[8], 2) |->
        mem_addr_o == {{4{$past(instr_i[7], 2)}}, $past(instr_i[7:0], 2)})
        else $error("access bank address wrong");
    nop_noread_a: assert property (nop_cycle_o && phase_o == 4'h4 |-> !mem_rd_o)
        else $error("squashed cycle read memory");
    adjust_noread_a: assert property (phase_o == 4'h1 && instr_valid_i && instr_i == 16'h0007 |=>
        !mem_rd_o [*3])
        else $error("decimal adjust read memory");
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle");
endmodule : cskda_core_asserts

// File: tb/cskda_fetch_model.sv
/* fetch pipeline and banked data memory model.
   assumes the core phase output is one-hot. */
`timescale 1ns/1ps
module cskda_fetch_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // core side
    input wire logic [3:0] phase_i,
    output logic instr_valid_o,
    output logic [15:0] instr_o,
    output logic instr_two_word_o,
    input wire logic [11:0] mem_addr_i,
    input wire logic mem_rd_i,
    output logic [7:0] mem_rdata_o
);
    logic [16:0] prog[$];
    int pc = 0;
    logic [7:0] mem[4096];
    logic [11:0] last_addr = 12'h000;
    logic [7:0] last_rd = 8'h00;
    logic [15:0] noise = 16'ha5c3;
    assign instr_valid_o = pc < prog.size();
    assign instr_o = instr_valid_o ? prog[pc][15:0] : noise;
    assign instr_two_word_o = instr_valid_o ? prog[pc][16] : noise[0];
    assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last_rd;
    always @(posedge clk_i) begin
        noise <= noise + 16'h3b1d;
        if (!rst_i && phase_i == 4'h1 && instr_valid_o) begin
            pc <= pc + 1;
        end
        if (mem_rd_i) begin
            last_rd <= mem[mem_addr_i];
        end
        if (mem_rd_i && phase_i == 4'h4) begin
            last_addr <= mem_addr_i;
        end
    end
endmodule : cskda_fetch_model

// File: tb/cskda_core_bench.sv
/* bench for the compare-skip core.
   assumes the core, its package and the fetch model are compiled first. */
`timescale 1ns/1ps
`include "cskda_params.svh"
module cskda_core_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic [15:0] instr_i;
    logic [11:0] mem_addr_o;
    logic [7:0] mem_rdata_i;
    logic [3:0] phase_o;
    logic wb_ack_o, instr_valid_i, instr_two_word_i, mem_rd_o, nop_cycle_o, skip_taken_o, cycle_end_o;
    int failures = 0;
    int tests_run = 0;
    int nops = 0;
    int skips = 0;
    cskda_core i_cskda_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .instr_two_word_i(instr_two_word_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_rdata_i(mem_rdata_i), .phase_o(phase_o), .nop_cycle_o(nop_cycle_o),
        .skip_taken_o(skip_taken_o), .cycle_end_o(cycle_end_o));
    cskda_fetch_model i_cskda_fetch_model (.clk_i(clk_i), .rst_i(rst_i), .phase_i(phase_o),
        .instr_valid_o(instr_valid_i), .instr_o(instr_i), .instr_two_word_o(instr_two_word_i),
        .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_rdata_o(mem_rdata_i));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (phase_o === 4'h4 && nop_cycle_o === 1'b1) nops++;
        if (skip_taken_o === 1'b1) skips++;
    end
    task automatic results();
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            failures++;
            results();
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, adr, d, r);
    endtask : wr
    task automatic rdc(input logic [7:0] adr, input string name, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, adr, 32'h0, r);
        check(name, r, exp);
    endtask : rdc
    // words are appended while phase two stands, so no fetch edge races the load
    task automatic run(input logic [16:0] w[$]);
        int n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (phase_o !== 4'h2 && n < 8);
        if (phase_o !== 4'h2) begin
            failures++;
            results();
        end
        nops = 0;
        skips = 0;
        foreach (w[i]) i_cskda_fetch_model.prog.push_back(w[i]);
        repeat (w.size() * 4 + 8) @(posedge clk_i);
    endtask : run
    task automatic cmp(input logic [15:0] op, input logic [7:0] w, input logic [7:0] f, input logic tw,
                       input logic skip, input logic [11:0] adr);
        wr(`CSKDA_OFF_WORK, {24'h0, w});
        wr(`CSKDA_OFF_FLAGS, 32'h3);
        i_cskda_fetch_model.mem[adr] = f;
        run('{{1'b0, op}, {tw, 16'h0000}, 17'h0, 17'h0});
        check("skips", skips, {31'h0, skip});
        check("nops", nops, skip ? (tw ? 32'h2 : 32'h1) : 32'h0);
        check("address", {20'h0, i_cskda_fetch_model.last_addr}, {20'h0, adr});
        rdc(`CSKDA_OFF_WORK, "work kept", {24'h0, w});
        rdc(`CSKDA_OFF_FLAGS, "flags kept", 32'h3);
    endtask : cmp
    task automatic decimal_adjust_work(input logic [7:0] w, input logic [1:0] fl);
        logic [3:0] lo;
        logic [4:0] hi;
        lo = (w[3:0] > 4'h9 || fl[1]) ? w[3:0] + 4'h6 : w[3:0];
        hi = (w[7:4] > 4'h9 || fl[0]) ? {1'b0, w[7:4]} + 5'h6 : {1'b0, w[7:4]};
        wr(`CSKDA_OFF_WORK, {24'h0, w});
        wr(`CSKDA_OFF_FLAGS, {30'h0, fl});
        run('{17'h00007});
        rdc(`CSKDA_OFF_WORK, "adjusted", {24'h0, hi[3:0], lo});
        rdc(`CSKDA_OFF_FLAGS, "adjust flags", {30'h0, fl[1], fl[0] | hi[4]});
    endtask : decimal_adjust_work
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`CSKDA_OFF_WORK, "work reset", 32'h0);
        rdc(`CSKDA_OFF_BANK, "bank reset", 32'h0);
        rdc(`CSKDA_OFF_FLAGS, "flags reset", 32'h0);
        rdc(8'h10, "unmapped", 32'h0);
        wr(`CSKDA_OFF_BANK, 32'h5);
        rdc(`CSKDA_OFF_BANK, "bank", 32'h5);
        cmp(16'h6212, 8'h55, 8'h55, 1'b1, 1'b1, 12'h012);
        cmp(16'h6334, 8'h55, 8'h54, 1'b0, 1'b0, 12'h534);
        cmp(16'h6480, 8'h55, 8'h56, 1'b0, 1'b1, 12'hf80);
        cmp(16'h6501, 8'h55, 8'h55, 1'b0, 1'b0, 12'h501);
        cmp(16'h607f, 8'h80, 8'h00, 1'b1, 1'b1, 12'h07f);
        cmp(16'h61ff, 8'h55, 8'hff, 1'b0, 1'b0, 12'h5ff);
        cmp(16'h6000, 8'h55, 8'h55, 1'b0, 1'b0, 12'h000);
        decimal_adjust_work(8'ha5, 2'h0);
        decimal_adjust_work(8'h99, 2'h0);
        decimal_adjust_work(8'h12, 2'h2);
        decimal_adjust_work(8'h3a, 2'h1);
        decimal_adjust_work(8'hfa, 2'h0);
        results();
    end
endmodule : cskda_core_bench
bind cskda_core cskda_core_asserts i_cskda_core_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_two_word_i(instr_two_word_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_rdata_i(mem_rdata_i), .phase_o(phase_o), .nop_cycle_o(nop_cycle_o), .skip_taken_o(skip_taken_o),
    .cycle_end_o(cycle_end_o));
